// [common/pesc_defines.vh]
`ifndef PESC_DEFINES_VH
`define PESC_DEFINES_VH

// Register bus geometry
`define PESC_ADDR_W       12
`define PESC_DATA_W       32

// Register addresses
`define PESC_SEL0_ADDR    12'h186
`define PESC_SEL1_ADDR    12'h187
`define PESC_CNT0_ADDR    12'h010
`define PESC_CNT1_ADDR    12'h011
`define PESC_STAT_ADDR    12'h020
`define PESC_MASK_ADDR    12'h021
`define PESC_LIVE_ADDR    12'h022

// Selection register fields
`define PESC_EVT_LSB      0
`define PESC_EVT_MSB      7
`define PESC_UQ_LSB       8
`define PESC_UQ_MSB       15
`define PESC_USR_BIT      16
`define PESC_KRN_BIT      17
`define PESC_MODE_BIT     18
`define PESC_PIN_BIT      19
`define PESC_INT_BIT      20
`define PESC_EN_BIT       22
`define PESC_INV_BIT      23
`define PESC_THR_LSB      24
`define PESC_THR_MSB      31

// Writable bits (bit 21 reserved, bit 22 only in the first register)
`define PESC_SEL0_WMASK   32'hFFDF_FFFF
`define PESC_SEL1_WMASK   32'hFF9F_FFFF

// Reset values
`define PESC_SEL_RST      32'h0000_0000
`define PESC_CNT_RST      32'h0000_0000
`define PESC_IRQ_RST      2'h0

// Event source and counter geometry
`define PESC_EVT_NUM      16
`define PESC_SUB_W        8
`define PESC_INC_W        4
`define PESC_CNT_W        32

`endif

// [design/pesc_evt_match.v]
`timescale 1ns/1ps
`include "pesc_defines.vh"

module pesc_evt_match (
   // Clock and reset
   input  wire                                    clock_i,
   input  wire                                    resetn_i,
   // Controls
   input  wire [31:0]                             sel_i,
   input  wire                                    glob_en_i,
   input  wire [1:0]                              cpl_i,
   // Event lines
   input  wire [`PESC_EVT_NUM*`PESC_SUB_W-1:0]    ev_sub_i,
   // Result
   output reg  [`PESC_INC_W-1:0]                  inc_o,
   output reg                                     active_o
);

   // Count of set bits in a sub-event group
   function [`PESC_INC_W-1:0] pesc_popcnt;
      input [`PESC_SUB_W-1:0] v;
      integer k;
      begin
         pesc_popcnt = {`PESC_INC_W{1'b0}};
         for (k = 0; k < `PESC_SUB_W; k = k + 1) begin
            pesc_popcnt = pesc_popcnt + {{(`PESC_INC_W-1){1'b0}}, v[k]};
         end
      end
   endfunction

   wire [7:0]                 code  = sel_i[`PESC_EVT_MSB:`PESC_EVT_LSB];
   wire [7:0]                 uq    = sel_i[`PESC_UQ_MSB:`PESC_UQ_LSB];
   wire [7:0]                 thr   = sel_i[`PESC_THR_MSB:`PESC_THR_LSB];
   wire [`PESC_SUB_W-1:0]     sub   = (code < `PESC_EVT_NUM) ?
                                      ev_sub_i[code[3:0]*`PESC_SUB_W +: `PESC_SUB_W] : {`PESC_SUB_W{1'b0}};
   wire [`PESC_SUB_W-1:0]     qual  = (uq == 8'h00) ? sub : (sub & uq);
   wire [`PESC_INC_W-1:0]     cnt   = pesc_popcnt(qual);
   wire                       priv  = (cpl_i == 2'b00) ? sel_i[`PESC_KRN_BIT] : sel_i[`PESC_USR_BIT];
   wire                       cmp   = ({4'h0, cnt} >= thr);
   wire                       hit   = sel_i[`PESC_INV_BIT] ? ~cmp : cmp;
   wire [`PESC_INC_W-1:0]     amt   = (thr == 8'h00) ? cnt : {{(`PESC_INC_W-1){1'b0}}, hit};
   wire                       act   = glob_en_i & priv & (amt != {`PESC_INC_W{1'b0}});
   reg                        act_r;

   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         act_r    <= 1'b0;
         inc_o    <= {`PESC_INC_W{1'b0}};
         active_o <= 1'b0;
      end else begin
         act_r    <= act;
         active_o <= act;
         if (sel_i[`PESC_MODE_BIT]) begin
            inc_o <= (act & ~act_r) ? {{(`PESC_INC_W-1){1'b0}}, 1'b1} : {`PESC_INC_W{1'b0}};
         end else begin
            inc_o <= act ? amt : {`PESC_INC_W{1'b0}};
         end
      end
   end

endmodule

// [design/pesc_counter.v]
`timescale 1ns/1ps
`include "pesc_defines.vh"

module pesc_counter (
   // Clock and reset
   input  wire                      clock_i,
   input  wire                      resetn_i,
   // Increment and software load
   input  wire [`PESC_INC_W-1:0]    inc_i,
   input  wire                      wr_i,
   input  wire [`PESC_CNT_W-1:0]    wdata_i,
   // State
   output reg  [`PESC_CNT_W-1:0]    count_o,
   output reg                       ovf_o
);

   wire [`PESC_CNT_W:0] sum = {1'b0, count_o} + {{(`PESC_CNT_W-`PESC_INC_W+1){1'b0}}, inc_i};

   // Load wins over counting; carry out flags wrap
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_o <= `PESC_CNT_RST;
         ovf_o   <= 1'b0;
      end else if (wr_i) begin
         count_o <= wdata_i;
         ovf_o   <= 1'b0;
      end else begin
         count_o <= sum[`PESC_CNT_W-1:0];
         ovf_o   <= sum[`PESC_CNT_W];
      end
   end

endmodule

// [design/pesc_top.v]
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "pesc_defines.vh"

module pesc_top (
   // Clock and reset
   input  wire                                    clock_i,
   input  wire                                    resetn_i,
   // Register port
   input  wire [`PESC_ADDR_W-1:0]                 addr_i,
   input  wire [`PESC_DATA_W-1:0]                 wdata_i,
   input  wire                                    wr_i,
   input  wire                                    rd_i,
   output reg  [`PESC_DATA_W-1:0]                 rdata_o,
   // Event side
   input  wire [1:0]                              current_privilege_level_i,
   input  wire [`PESC_EVT_NUM*`PESC_SUB_W-1:0]    ev_sub_i,
   // Overflow signalling
   output reg  [1:0]                              breakpoint_monitor_output_pin_o,
   output wire                                    local_interrupt_controller_o
);

   // Address match shared by write and read decode
   function pesc_hit;
      input [`PESC_ADDR_W-1:0] a;
      input [`PESC_ADDR_W-1:0] t;
      begin
         pesc_hit = (a == t);
      end
   endfunction

   // Selection registers
   reg  [31:0]               first_selection_register_r;
   reg  [31:0]               second_selection_register_r;
   // Sticky overflow status and mask
   reg  [1:0]                irq_stat_r;
   reg  [1:0]                irq_stat_nxt;
   reg  [1:0]                irq_mask_r;

   wire [`PESC_CNT_W-1:0]    count0;
   wire [`PESC_CNT_W-1:0]    count1;
   wire                      ovf0;
   wire                      ovf1;
   wire [`PESC_INC_W-1:0]    inc0;
   wire [`PESC_INC_W-1:0]    inc1;
   wire                      act0;
   wire                      act1;

   // Write decode
   wire wr_sel0 = wr_i & pesc_hit(addr_i, `PESC_SEL0_ADDR);
   wire wr_sel1 = wr_i & pesc_hit(addr_i, `PESC_SEL1_ADDR);
   wire wr_cnt0 = wr_i & pesc_hit(addr_i, `PESC_CNT0_ADDR);
   wire wr_cnt1 = wr_i & pesc_hit(addr_i, `PESC_CNT1_ADDR);
   wire wr_stat = wr_i & pesc_hit(addr_i, `PESC_STAT_ADDR);
   wire wr_mask = wr_i & pesc_hit(addr_i, `PESC_MASK_ADDR);

   // global enable from first register only
   wire glob_en = first_selection_register_r[`PESC_EN_BIT];

   // Selection register storage
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         first_selection_register_r  <= `PESC_SEL_RST;
         second_selection_register_r <= `PESC_SEL_RST;
      end else begin
         if (wr_sel0) begin
            first_selection_register_r <= wdata_i & `PESC_SEL0_WMASK;
         end
         if (wr_sel1) begin
            second_selection_register_r <= wdata_i & `PESC_SEL1_WMASK;
         end
      end
   end

   // Event qualification, both counters
   pesc_evt_match u_match0 (
      .clock_i   (clock_i),
      .resetn_i  (resetn_i),
      .sel_i     (first_selection_register_r),
      .glob_en_i (glob_en),
      .cpl_i     (current_privilege_level_i),
      .ev_sub_i  (ev_sub_i),
      .inc_o     (inc0),
      .active_o  (act0)
   );

   pesc_evt_match u_match1 (
      .clock_i   (clock_i),
      .resetn_i  (resetn_i),
      .sel_i     (second_selection_register_r),
      .glob_en_i (glob_en),
      .cpl_i     (current_privilege_level_i),
      .ev_sub_i  (ev_sub_i),
      .inc_o     (inc1),
      .active_o  (act1)
   );

   // Counter storage
   pesc_counter u_cnt0 (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .inc_i    (inc0),
      .wr_i     (wr_cnt0),
      .wdata_i  (wdata_i),
      .count_o  (count0),
      .ovf_o    (ovf0)
   );

   pesc_counter u_cnt1 (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .inc_i    (inc1),
      .wr_i     (wr_cnt1),
      .wdata_i  (wdata_i),
      .count_o  (count1),
      .ovf_o    (ovf1)
   );

   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         breakpoint_monitor_output_pin_o <= 2'b00;
      end else begin
         breakpoint_monitor_output_pin_o[0] <= ovf0 & first_selection_register_r[`PESC_PIN_BIT];
         breakpoint_monitor_output_pin_o[1] <= ovf1 & second_selection_register_r[`PESC_PIN_BIT];
      end
   end

   wire [1:0] ovf_evt = {ovf1 & second_selection_register_r[`PESC_INT_BIT],
                         ovf0 & first_selection_register_r[`PESC_INT_BIT]};

   // Write one clears, a new overflow wins
   always @* begin
      irq_stat_nxt = irq_stat_r;
      if (wr_stat) begin
         irq_stat_nxt = irq_stat_nxt & ~wdata_i[1:0];
      end
      irq_stat_nxt = irq_stat_nxt | ovf_evt;
   end

   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_stat_r <= `PESC_IRQ_RST;
         irq_mask_r <= `PESC_IRQ_RST;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         if (wr_mask) begin
            irq_mask_r <= wdata_i[1:0];
         end
      end
   end

   assign local_interrupt_controller_o = |(irq_stat_r & irq_mask_r);

   // Read data stands one cycle only
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (!rd_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (pesc_hit(addr_i, `PESC_SEL0_ADDR)) begin
         rdata_o <= first_selection_register_r;
      end else if (pesc_hit(addr_i, `PESC_SEL1_ADDR)) begin
         rdata_o <= second_selection_register_r;
      end else if (pesc_hit(addr_i, `PESC_CNT0_ADDR)) begin
         rdata_o <= count0;
      end else if (pesc_hit(addr_i, `PESC_CNT1_ADDR)) begin
         rdata_o <= count1;
      end else if (pesc_hit(addr_i, `PESC_STAT_ADDR)) begin
         rdata_o <= {30'h0000_0000, irq_stat_r};
      end else if (pesc_hit(addr_i, `PESC_MASK_ADDR)) begin
         rdata_o <= {30'h0000_0000, irq_mask_r};
      end else if (pesc_hit(addr_i, `PESC_LIVE_ADDR)) begin
         rdata_o <= {27'h000_0000, current_privilege_level_i, glob_en, act1, act0};
      end else begin
         rdata_o <= 32'h0000_0000; // Unmapped reads zero
      end
   end

endmodule

// [tb/pesc_properties.sv]
`timescale 1ns/1ps
`include "pesc_defines.vh"
module pesc_checker (
   // Clock and reset
   input logic        clock_i,
   input logic        resetn_i,
   // Register port
   input logic [11:0] addr_i,
   input logic [31:0] wdata_i,
   input logic        wr_i,
   input logic        rd_i,
   input logic [31:0] rdata_o,
   // Overflow signalling
   input logic [1:0]  breakpoint_monitor_output_pin_o,
   input logic        local_interrupt_controller_o
);
   // One clock domain for every check
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   a_sel0_readback: assert property (
      (wr_i && addr_i == `PESC_SEL0_ADDR) ##1 (rd_i && addr_i == `PESC_SEL0_ADDR)
      |=> rdata_o == ($past(wdata_i, 2) & `PESC_SEL0_WMASK)) else $error("first selection readback wrong");
   a_sel1_readback: assert property (
      (wr_i && addr_i == `PESC_SEL1_ADDR) ##1 (rd_i && addr_i == `PESC_SEL1_ADDR)
      |=> rdata_o == ($past(wdata_i, 2) & `PESC_SEL1_WMASK)) else $error("second selection readback wrong");
   a_cnt0_readback: assert property (
      (wr_i && addr_i == `PESC_CNT0_ADDR) ##1 (rd_i && addr_i == `PESC_CNT0_ADDR)
      |=> rdata_o == $past(wdata_i, 2)) else $error("counter load lost");
   a_mask_readback: assert property (
      (wr_i && addr_i == `PESC_MASK_ADDR) ##1 (rd_i && addr_i == `PESC_MASK_ADDR)
      |=> rdata_o == ($past(wdata_i, 2) & 32'h0000_0003)) else $error("mask readback wrong");
   a_unmapped_zero: assert property (
      rd_i && addr_i[11:9] != 3'h0 |=> rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
   a_rdata_idle_zero: assert property (
      !$past(rd_i) |-> rdata_o == 32'h0000_0000) else $error("read data outside read slot");
   a_irq_mask_off: assert property (
      wr_i && addr_i == `PESC_MASK_ADDR && wdata_i[1:0] == 2'b00
      |=> !local_interrupt_controller_o) else $error("masked interrupt still high");
   a_irq_fall_write: assert property (
      $fell(local_interrupt_controller_o) |-> $past(wr_i)) else $error("interrupt dropped without write");
   a_pin_single_pulse: assert property (
      breakpoint_monitor_output_pin_o != 2'b00
      |=> (breakpoint_monitor_output_pin_o & $past(breakpoint_monitor_output_pin_o)) == 2'b00)
      else $error("overflow pin longer than one cycle");
endmodule

// [tb/pesc_ovf_sink.sv]
`timescale 1ns/1ps
module pesc_ovf_sink (
   // Clock and reset
   input  logic       clock_i,
   input  logic       resetn_i,
   // Overflow signalling
   input  logic [1:0] pin_i,
   input  logic       irq_i,
   // Tallies
   output logic [7:0] pulses_o,
   output logic [7:0] irq_edges_o
);
   logic irq_q;
   // Tally pin pulses and interrupt assertions
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pulses_o    <= 8'h00;
         irq_edges_o <= 8'h00;
         irq_q       <= 1'b0;
      end else begin
         pulses_o    <= pulses_o + 8'(pin_i[0]) + 8'(pin_i[1]);
         irq_edges_o <= irq_edges_o + 8'(irq_i & ~irq_q);
         irq_q       <= irq_i;
      end
   end
endmodule

// [tb/pesc_top_tb.sv]
`timescale 1ns/1ps
`include "pesc_defines.vh"
module pesc_top_tb;
   logic         clock_i;
   logic         resetn_i;
   logic [11:0]  addr_i;
   logic [31:0]  wdata_i;
   logic         wr_i;
   logic         rd_i;
   logic [31:0]  rdata_o;
   logic [1:0]   current_privilege_level;
   logic [127:0] ev_sub;
   logic [1:0]   pin;
   logic         irq;
   logic [7:0]   pulses;
   logic [7:0]   irq_edges;
   logic [31:0]  d;
   logic [31:0]  tab [0:29];
   int           mismatches;
   int           compares;

   pesc_top u_pesc_top (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .current_privilege_level_i(current_privilege_level), .ev_sub_i(ev_sub),
      .breakpoint_monitor_output_pin_o(pin), .local_interrupt_controller_o(irq));
   pesc_ovf_sink u_pesc_ovf_sink (.clock_i(clock_i), .resetn_i(resetn_i), .pin_i(pin), .irq_i(irq),
      .pulses_o(pulses), .irq_edges_o(irq_edges));

   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clock_i);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      wr_i   <= 1'b0;
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      @(negedge clock_i);
      v = rdata_o;
      @(posedge clock_i);
   endtask
   task automatic idle(input int n);
      wr_i <= 1'b0;
      repeat (n) @(posedge clock_i);
   endtask
   task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", s, exp, got);
      end
   endtask
   // One overflow of counter zero under a given selection
   task automatic ovf(input logic [31:0] sel, input logic [31:0] st, input logic [7:0] np);
      wr(`PESC_SEL0_ADDR, sel);
      wr(`PESC_MASK_ADDR, 32'h0000_0001);
      wr(`PESC_CNT0_ADDR, 32'hFFFF_FFFF);
      rd(`PESC_CNT0_ADDR, d);
      ev_sub[31:24] <= 8'h01;
      idle(1);
      ev_sub[31:24] <= 8'h00;
      idle(6);
      rd(`PESC_STAT_ADDR, d);
      chk("status", d, st);
      chk("irq", {31'h0, irq}, st);
      chk("pulses", {24'h0, pulses}, {24'h0, np});
      wr(`PESC_STAT_ADDR, 32'h0000_0003);
      idle(1);
      chk("irq_clr", {31'h0, irq}, 32'h0000_0000);
   endtask
   task automatic test_done;
      if (mismatches == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Clock
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge clock_i);
      mismatches++;
      test_done;
   end
   // Main sequence
   initial begin
      tab = '{32'h0045_0003, 32'h0001_0003, 32'h1, 32'h01, 32'h01, 32'h05,
              32'h0042_0003, 32'h0001_0003, 32'h0, 32'hFF, 32'h28, 32'h00,
              32'h0041_0F03, 32'h0001_0004, 32'h2, 32'hFF, 32'h14, 32'h00,
              32'h0001_0003, 32'h0001_0003, 32'h3, 32'hFF, 32'h00, 32'h00,
              32'h0241_0003, 32'h0285_0003, 32'h1, 32'h07, 32'h05, 32'h01};
      {resetn_i, addr_i, wdata_i, wr_i, rd_i, current_privilege_level, ev_sub, mismatches, compares} = '0;
      repeat (16) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(posedge clock_i);
      rd(`PESC_SEL0_ADDR, d);
      chk("sel0_rst", d, `PESC_SEL_RST);
      wr(`PESC_SEL0_ADDR, 32'hFFFF_FFFF);
      rd(`PESC_SEL0_ADDR, d);
      chk("sel0", d, 32'hFFDF_FFFF);
      wr(`PESC_SEL1_ADDR, 32'hFFFF_FFFF);
      rd(`PESC_SEL1_ADDR, d);
      chk("sel1", d, 32'hFF9F_FFFF);
      rd(12'h300, d);
      chk("unmapped", d, 32'h0000_0000);
      for (int i = 0; i < 5; i++) begin
         wr(`PESC_SEL0_ADDR, tab[i*6]);
         wr(`PESC_SEL1_ADDR, tab[i*6+1]);
         current_privilege_level <= tab[i*6+2][1:0];
         idle(4);
         wr(`PESC_CNT0_ADDR, 32'h0000_0000);
         wr(`PESC_CNT1_ADDR, 32'h0000_0000);
         ev_sub[31:24] <= tab[i*6+3][7:0];
         idle(5);
         ev_sub[31:24] <= 8'h00;
         idle(6);
         rd(`PESC_CNT0_ADDR, d);
         chk("count0", d, tab[i*6+4]);
         rd(`PESC_CNT1_ADDR, d);
         chk("count1", d, tab[i*6+5]);
      end
      ovf(32'h0059_0003, 32'h0000_0001, 8'h01);
      ovf(32'h0049_0003, 32'h0000_0000, 8'h02);
      ovf(32'h0051_0003, 32'h0000_0001, 8'h02);
      wr(`PESC_MASK_ADDR, 32'h0000_0000);
      rd(`PESC_MASK_ADDR, d);
      chk("mask", d, 32'h0000_0000);
      // Live view: level 1, enable on, inverted threshold keeps counter one qualifying
      rd(`PESC_LIVE_ADDR, d);
      chk("live", d, 32'h0000_000E);
      chk("irq_edges", {24'h0, irq_edges}, 32'h0000_0002);
      test_done;
   end
endmodule

bind pesc_top pesc_checker u_pesc_checker (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .breakpoint_monitor_output_pin_o(breakpoint_monitor_output_pin_o),
   .local_interrupt_controller_o(local_interrupt_controller_o));
